/* File: logic/psm_ctrl.sv */
// Power saving mode controller: wait and stop entry, wake-up and resume decision.
// Assumes core, interrupt sources and reset requests are synchronous to CORE_CLK.
`timescale 1ns/1ps
// What this block does
// [RULE1] Wait instruction halts the core; memory and peripherals keep running.
// [RULE2] In wait the active oscillator keeps clocking the peripherals.
// [RULE3] An enabled peripheral interrupt such as the timer ends wait.
// [RULE4] Pin or watchdog reset during wait abandons it and resets normally.
// [RULE5] Wake from wait by interrupt resumes with no stabilisation delay.
// [RULE6] With the watchdog active a stop request performs a wait instead.
// [RULE7] Stop halts oscillator and core; only external interrupt, NMI or reset pin exits.
// [RULE8] Wake from stop waits for oscillator stabilisation before running.
// [RULE9] External reset pin during stop ends it with a normal reset.
// [RULE10] Waking never changes the oscillator selection.
// [RULE11] Sleep from main routine: service the waking interrupt, then continue.
// [RULE12] Sleep in NMI routine: any interrupt wakes, continue in NMI context.
// [RULE13] Sleep in interrupt routine woken by normal interrupt: continue routine.
// [RULE14] Sleep in interrupt routine woken by NMI: run NMI routine first.
// [RULE15] Global enable clear: nothing wakes the device, only reset restarts it.
// [RULE16] Sleep instruction is skipped while an enabled request is pending.
// [RULE17] Software switches the auxiliary oscillator on before a wait.
// [RULE18] Global enable is bit 4 of write-only register 0C8h, reset 00h.
// [RULE19] Stabilisation delay is a parameterised cycle count.
module psm_ctrl #(
  parameter int STAB_CYCLES = psm_pkg::STAB_CYCLES
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESET_N,
  // Data space write port
  input  wire logic       DATA_WE,
  input  wire logic [7:0] DATA_ADDR,
  input  wire logic [7:0] DATA_WDATA,
  // Core sleep instructions and context
  input  wire logic       OP_WAIT,
  input  wire logic       OP_STOP,
  input  wire logic [1:0] CORE_CTX,
  // Interrupt requests, individual masks already applied
  input  wire logic       IRQ_PERIPH,
  input  wire logic       IRQ_EXT,
  input  wire logic       NMI_REQ,
  // Watchdog and reset pin
  input  wire logic       WDG_ACTIVE,
  input  wire logic       WDG_RESET,
  input  wire logic       EXT_RESET,
  // Oscillator selection from software
  input  wire logic       OSC_SEL_AUX,
  input  wire logic       AUX_OSC_ON,
  // Power and clock control
  output logic            CORE_HALT,
  output logic            PERIPH_CLK_EN,
  output logic            MAIN_OSC_EN,
  output logic            AUX_OSC_EN,
  output logic            AUX_SELECTED,
  output logic            GLOBAL_IRQ_ENABLE,
  output logic [1:0]      POWER_MODE,
  // Events towards the core
  output logic            SLEEP_SKIP,
  output logic            WAKE,
  output logic [1:0]      WAKE_ACTION,
  output logic            RESET_REQ
);

  typedef struct packed {
    psm_pkg::psm_mode_t state;
    psm_pkg::psm_ctx_t  ctx;
    psm_pkg::psm_act_t  act;
    logic [7:0]         ior;
    logic               aux_sel;
    logic               halt;
    logic               periph_clk;
    logic               main_osc;
    logic               aux_osc;
    logic               skip;
    logic               wake;
    logic               rst_req;
    logic               stab_start;
  } psm_state_t;

  psm_state_t s;
  psm_state_t next_s;
  logic       rst_n;
  logic       stab_done;
  logic       any_rst;
  logic       pending;
  logic       wait_wake;
  logic       stop_wake;

  // Resume decision from the entry context and whether the waking request is the NMI.
  function automatic psm_pkg::psm_act_t wake_action(input psm_pkg::psm_ctx_t ctx, input logic nmi);
    psm_pkg::psm_act_t a;
    a = psm_pkg::ACT_RESUME;
    case (ctx)
      psm_pkg::CTX_MAIN: begin
        a = nmi ? psm_pkg::ACT_SERVICE_NMI : psm_pkg::ACT_SERVICE_IRQ; // [RULE11]
      end
      psm_pkg::CTX_NMI: begin
        a = psm_pkg::ACT_RESUME; // [RULE12]
      end
      psm_pkg::CTX_IRQ: begin
        a = nmi ? psm_pkg::ACT_SERVICE_NMI : psm_pkg::ACT_RESUME; // [RULE13] [RULE14]
      end
      default: begin
        a = psm_pkg::ACT_RESUME;
      end
    endcase
    return a;
  endfunction

  psm_rst_sync u_rst_sync (
    .clk       (CORE_CLK),
    .rst_in_n  (RESET_N),
    .rst_out_n (rst_n)
  );

  psm_stab_timer #(
    .STAB_CYCLES (STAB_CYCLES)
  ) u_stab_timer (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .start (s.stab_start),
    .abort (EXT_RESET),
    .done  (stab_done)
  );

  assign any_rst = EXT_RESET | WDG_RESET;
  // The NMI always counts as pending; maskable ones only with the global enable set.
  assign pending = NMI_REQ | (s.ior[psm_pkg::IOR_GEN_BIT] & (IRQ_PERIPH | IRQ_EXT));
  // Without the global enable no source, not even the NMI, raises a wake-up.
  assign wait_wake = s.ior[psm_pkg::IOR_GEN_BIT] & (IRQ_PERIPH | IRQ_EXT | NMI_REQ); // [RULE3] [RULE15]
  assign stop_wake = s.ior[psm_pkg::IOR_GEN_BIT] & (IRQ_EXT | NMI_REQ); // [RULE7] [RULE15]

  always_comb begin
    next_s            = s;
    next_s.skip       = 1'b0;
    next_s.wake       = 1'b0;
    next_s.rst_req    = 1'b0;
    next_s.stab_start = 1'b0;
    next_s.aux_sel    = OSC_SEL_AUX; // [RULE10]
    if (DATA_WE && DATA_ADDR == psm_pkg::IOR_ADDR) begin
      next_s.ior = DATA_WDATA; // [RULE18]
    end
    case (s.state)
      psm_pkg::PM_RUN: begin
        if (OP_WAIT || OP_STOP) begin
          next_s.ctx = psm_pkg::psm_ctx_t'(CORE_CTX);
          if (pending) begin
            next_s.skip = 1'b1; // [RULE16]
          end else if (OP_STOP && !WDG_ACTIVE) begin
            next_s.state = psm_pkg::PM_STOP; // [RULE7]
          end else begin
            next_s.state = psm_pkg::PM_WAIT; // [RULE1] [RULE6]
          end
        end
      end
      psm_pkg::PM_WAIT: begin
        if (any_rst) begin
          next_s.rst_req = 1'b1; // [RULE4]
          next_s.state   = psm_pkg::PM_RUN;
        end else if (wait_wake) begin
          next_s.wake  = 1'b1; // [RULE5]
          next_s.act   = wake_action(s.ctx, NMI_REQ);
          next_s.state = psm_pkg::PM_RUN;
        end
      end
      psm_pkg::PM_STOP: begin
        if (EXT_RESET) begin
          next_s.rst_req = 1'b1; // [RULE9]
          next_s.state   = psm_pkg::PM_RUN;
        end else if (stop_wake) begin
          next_s.act        = wake_action(s.ctx, NMI_REQ);
          next_s.stab_start = 1'b1; // [RULE8]
          next_s.state      = psm_pkg::PM_STAB;
        end
      end
      psm_pkg::PM_STAB: begin
        if (EXT_RESET) begin
          next_s.rst_req = 1'b1; // [RULE9]
          next_s.state   = psm_pkg::PM_RUN;
        end else if (stab_done) begin
          next_s.wake  = 1'b1; // [RULE8]
          next_s.state = psm_pkg::PM_RUN;
        end
      end
      default: begin
        next_s.state = psm_pkg::PM_RUN;
      end
    endcase
    next_s.halt       = next_s.state != psm_pkg::PM_RUN; // [RULE1] [RULE7]
    // Peripherals stay clocked in wait; they lose their clock only in stop and stabilisation.
    next_s.periph_clk = next_s.state != psm_pkg::PM_STOP && next_s.state != psm_pkg::PM_STAB; // [RULE2]
    next_s.main_osc   = next_s.state != psm_pkg::PM_STOP; // [RULE2] [RULE7]
    next_s.aux_osc    = AUX_OSC_ON && next_s.state != psm_pkg::PM_STOP; // [RULE2]
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s            <= '0;
      s.state      <= psm_pkg::PM_RUN;
      s.ior        <= psm_pkg::IOR_RESET; // [RULE18]
      s.periph_clk <= 1'b1;
      s.main_osc   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign CORE_HALT         = s.halt;
  assign PERIPH_CLK_EN     = s.periph_clk;
  assign MAIN_OSC_EN       = s.main_osc;
  assign AUX_OSC_EN        = s.aux_osc;
  assign AUX_SELECTED      = s.aux_sel;
  assign GLOBAL_IRQ_ENABLE = s.ior[psm_pkg::IOR_GEN_BIT];
  assign POWER_MODE        = s.state;
  assign SLEEP_SKIP        = s.skip;
  assign WAKE              = s.wake;
  assign WAKE_ACTION       = s.act;
  assign RESET_REQ         = s.rst_req;

  // Cycles spent in stabilisation, for checking only.
  logic [psm_pkg::STAB_W-1:0] stab_len;

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      stab_len <= '0;
    end else if (s.state != psm_pkg::PM_STAB) begin
      stab_len <= '0;
    end else if (stab_len != '1) begin
      stab_len <= stab_len + 1'b1;
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!rst_n);

  a_wait_entry_halts: assert property ( // [RULE1]
    s.state == psm_pkg::PM_RUN && OP_WAIT && !OP_STOP && !pending
    |=> POWER_MODE == psm_pkg::PM_WAIT && CORE_HALT && PERIPH_CLK_EN)
    else $error("wait entry did not halt the core");

  a_wait_keeps_clock: assert property ( // [RULE2]
    POWER_MODE == psm_pkg::PM_WAIT && AUX_OSC_ON |=> PERIPH_CLK_EN && MAIN_OSC_EN && AUX_OSC_EN)
    else $error("oscillator stopped during wait");

  a_wait_irq_wake: assert property ( // [RULE3]
    POWER_MODE == psm_pkg::PM_WAIT && GLOBAL_IRQ_ENABLE && IRQ_PERIPH && !any_rst
    |=> WAKE && POWER_MODE == psm_pkg::PM_RUN)
    else $error("peripheral interrupt did not end wait");

  a_wait_reset_exit: assert property ( // [RULE4]
    POWER_MODE == psm_pkg::PM_WAIT && WDG_RESET |=> RESET_REQ && !WAKE && !CORE_HALT)
    else $error("reset did not abandon wait");

  a_wait_no_delay: assert property ( // [RULE5]
    $rose(WAKE) && $past(POWER_MODE) == psm_pkg::PM_WAIT |-> !CORE_HALT && $past(CORE_HALT))
    else $error("wake from wait was delayed");

  a_stop_blocked_wdg: assert property ( // [RULE6]
    s.state == psm_pkg::PM_RUN && OP_STOP && WDG_ACTIVE && !pending
    |=> POWER_MODE == psm_pkg::PM_WAIT ##1 MAIN_OSC_EN)
    else $error("stop entered with watchdog active");

  a_stop_quiet: assert property ( // [RULE7]
    POWER_MODE == psm_pkg::PM_STOP && !IRQ_EXT && !NMI_REQ && !EXT_RESET
    |=> POWER_MODE == psm_pkg::PM_STOP && !MAIN_OSC_EN && !PERIPH_CLK_EN && CORE_HALT)
    else $error("stop left without an external event");

  a_stab_length: assert property ( // [RULE8]
    POWER_MODE == psm_pkg::PM_STAB && stab_done && !EXT_RESET
    |-> stab_len >= psm_pkg::STAB_W'(STAB_CYCLES) ##1 WAKE)
    else $error("stop wake-up shorter than stabilisation time");

  a_stop_ext_reset: assert property ( // [RULE9]
    POWER_MODE == psm_pkg::PM_STOP && EXT_RESET |=> RESET_REQ && POWER_MODE == psm_pkg::PM_RUN)
    else $error("reset pin did not end stop");

  a_wake_keeps_osc: assert property ( // [RULE10]
    WAKE |-> AUX_SELECTED == $past(OSC_SEL_AUX))
    else $error("wake changed oscillator selection");

  a_main_ctx_service: assert property ( // [RULE11]
    s.state == psm_pkg::PM_WAIT && s.ctx == psm_pkg::CTX_MAIN && wait_wake && !NMI_REQ && !any_rst
    |=> WAKE && WAKE_ACTION == psm_pkg::ACT_SERVICE_IRQ)
    else $error("main context wake did not service the interrupt");

  a_nmi_ctx_resume: assert property ( // [RULE12]
    s.state == psm_pkg::PM_WAIT && s.ctx == psm_pkg::CTX_NMI && wait_wake && !any_rst
    |=> WAKE && WAKE_ACTION == psm_pkg::ACT_RESUME)
    else $error("NMI context wake did not resume");

  a_irq_ctx_resume: assert property ( // [RULE13]
    s.state == psm_pkg::PM_WAIT && s.ctx == psm_pkg::CTX_IRQ && wait_wake && !NMI_REQ && !any_rst
    |=> WAKE_ACTION == psm_pkg::ACT_RESUME)
    else $error("interrupt context wake did not resume");

  a_irq_ctx_nmi: assert property ( // [RULE14]
    (s.state == psm_pkg::PM_WAIT || s.state == psm_pkg::PM_STOP) && s.ctx == psm_pkg::CTX_IRQ
    && s.ior[psm_pkg::IOR_GEN_BIT] && NMI_REQ && !any_rst |=> WAKE_ACTION == psm_pkg::ACT_SERVICE_NMI)
    else $error("NMI wake in interrupt context not serviced first");

  a_gen_off_no_wake: assert property ( // [RULE15]
    (POWER_MODE == psm_pkg::PM_WAIT || POWER_MODE == psm_pkg::PM_STOP) && !GLOBAL_IRQ_ENABLE
    && !any_rst |=> !WAKE && CORE_HALT)
    else $error("woke with global enable clear");

  a_skip_pending: assert property ( // [RULE16]
    s.state == psm_pkg::PM_RUN && (OP_WAIT || OP_STOP) && pending |=> SLEEP_SKIP && !CORE_HALT)
    else $error("sleep entered with a request pending");

  a_ior_gen_write: assert property ( // [RULE18]
    DATA_WE && DATA_ADDR == psm_pkg::IOR_ADDR |=> GLOBAL_IRQ_ENABLE == $past(DATA_WDATA[psm_pkg::IOR_GEN_BIT]))
    else $error("global enable not taken from bit 4");

endmodule

/* File: common/psm_pkg.sv */
// Shared constants and types for the power saving mode controller.
// Assumes a single 10 MHz core clock and a core that reports its context.
package psm_pkg;

  // Core clock rate.
  localparam int CLK_KHZ = 10000;

  // Interrupt option register: address on the data space and global enable position.
  localparam logic [7:0] IOR_ADDR    = 8'hc8;
  localparam logic [7:0] IOR_RESET   = 8'h00;
  localparam int         IOR_GEN_BIT = 4;

  // Oscillator stabilisation time after a wake from stop, in microseconds.
  localparam int STAB_TIME_US = 200;
  localparam int STAB_CYCLES  = (STAB_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int STAB_W       = 16;

  // Power mode, Gray coded in the order run, wait, stop, stabilise.
  typedef enum logic [1:0] {
    PM_RUN  = 2'h0,
    PM_WAIT = 2'h1,
    PM_STOP = 2'h3,
    PM_STAB = 2'h2
  } psm_mode_t;

  // Core context at the moment the sleep instruction was executed.
  typedef enum logic [1:0] {
    CTX_MAIN = 2'h0,
    CTX_IRQ  = 2'h1,
    CTX_NMI  = 2'h2
  } psm_ctx_t;

  // What the core does when it is woken.
  typedef enum logic [1:0] {
    ACT_RESUME      = 2'h0,
    ACT_SERVICE_IRQ = 2'h1,
    ACT_SERVICE_NMI = 2'h2
  } psm_act_t;

endpackage

/* File: logic/psm_rst_sync.sv */
// Reset release synchroniser for the power saving mode controller.
// Assumes an asynchronous active low reset pin.
`timescale 1ns/1ps
module psm_rst_sync (
  // Clock and raw reset
  input  wire logic clk,
  input  wire logic rst_in_n,
  // Synchronised reset
  output logic      rst_out_n
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } psm_sync_t;

  psm_sync_t s;
  psm_sync_t next_s;

  always_comb begin
    next_s        = s;
    next_s.stage1 = 1'b1;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rst_out_n = s.stage2;

endmodule

/* File: logic/psm_stab_timer.sv */
// Oscillator stabilisation timer used after a wake from stop.
// Assumes a one-cycle start pulse; gives a one-cycle done pulse.
`timescale 1ns/1ps
module psm_stab_timer #(
  parameter int STAB_CYCLES = psm_pkg::STAB_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  input  wire logic abort,
  output logic      done
);

  typedef struct packed {
    logic                      busy;
    logic [psm_pkg::STAB_W-1:0] cnt;
    logic                      done;
  } psm_timer_t;

  psm_timer_t s;
  psm_timer_t next_s;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (abort) begin
      next_s.busy = 1'b0;
    end else if (start) begin
      next_s.busy = 1'b1;
      next_s.cnt  = psm_pkg::STAB_W'(STAB_CYCLES - 1); // [RULE19]
    end else if (s.busy) begin
      if (s.cnt == '0) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;

endmodule

/* File: bench/psm_core_model.sv */
// Behavioural core model: turns one-cycle sleep requests into sleep instructions.
// Assumes bench requests change just after a rising edge of clk.
`timescale 1ns/1ps
module psm_core_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Requests from the bench
  input  wire logic req_wait,
  input  wire logic req_stop,
  input  wire logic want_aux,
  // Core side of the controller
  input  wire logic halt,
  output logic      op_wait,
  output logic      op_stop,
  output logic      aux_on
);
  // A halted core fetches nothing, so it issues no sleep instruction.
  // A wait is held back until the auxiliary oscillator setting is in place.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_wait <= 1'b0;
      op_stop <= 1'b0;
      aux_on  <= 1'b0;
    end else begin
      aux_on  <= want_aux;
      op_wait <= req_wait & ~halt & (aux_on == want_aux);
      op_stop <= req_stop & ~halt;
    end
  end
endmodule

/* File: bench/psm_tb.sv */
// Self-checking bench for the power saving mode controller.
// Assumes a shortened stabilisation count and a behavioural core model.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH at %0t: %s", $time, msg); end end
module testbench;
  localparam int STAB = 4;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, req_wait = 1'b0, req_stop = 1'b0, want_aux = 1'b0;
  logic irq_p = 1'b0, irq_e = 1'b0, nmi = 1'b0, wdg_act = 1'b0, wdg_rst = 1'b0, ext_rst = 1'b0;
  logic osc_sel = 1'b0, op_wait, op_stop, aux_on;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [1:0] ctx = 2'h0;
  logic CORE_HALT, PERIPH_CLK_EN, MAIN_OSC_EN, AUX_OSC_EN, AUX_SELECTED, GLOBAL_IRQ_ENABLE;
  logic SLEEP_SKIP, WAKE, RESET_REQ;
  logic [1:0] POWER_MODE, WAKE_ACTION;
  int err_count = 0, num_checks = 0, cycles = 0;

  always #50 clk = ~clk;

  psm_ctrl #(.STAB_CYCLES(STAB)) psm_ctrl_inst (
    .CORE_CLK(clk), .RESET_N(rst_n), .DATA_WE(we), .DATA_ADDR(addr), .DATA_WDATA(wdata),
    .OP_WAIT(op_wait), .OP_STOP(op_stop), .CORE_CTX(ctx), .IRQ_PERIPH(irq_p), .IRQ_EXT(irq_e),
    .NMI_REQ(nmi), .WDG_ACTIVE(wdg_act), .WDG_RESET(wdg_rst), .EXT_RESET(ext_rst),
    .OSC_SEL_AUX(osc_sel), .AUX_OSC_ON(aux_on), .CORE_HALT(CORE_HALT), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .MAIN_OSC_EN(MAIN_OSC_EN), .AUX_OSC_EN(AUX_OSC_EN), .AUX_SELECTED(AUX_SELECTED),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .POWER_MODE(POWER_MODE), .SLEEP_SKIP(SLEEP_SKIP),
    .WAKE(WAKE), .WAKE_ACTION(WAKE_ACTION), .RESET_REQ(RESET_REQ));

  psm_core_model psm_core_model_inst (
    .clk(clk), .rst_n(rst_n), .req_wait(req_wait), .req_stop(req_stop), .want_aux(want_aux),
    .halt(CORE_HALT), .op_wait(op_wait), .op_stop(op_stop), .aux_on(aux_on));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("MISMATCH at %0t: timeout", $time);
      close_out();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); we <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); we <= 1'b0;
  endtask

  // Returns just after the edge at which the controller takes the instruction.
  task automatic sleep(input logic stp, input logic [1:0] c);
    @(posedge clk); ctx <= c; req_stop <= stp; req_wait <= ~stp;
    @(posedge clk); req_stop <= 1'b0; req_wait <= 1'b0;
    @(posedge clk); #1;
  endtask

  task automatic pulse_reset(input logic wdg);
    @(posedge clk); wdg_rst <= wdg; ext_rst <= ~wdg;
    @(posedge clk); wdg_rst <= 1'b0; ext_rst <= 1'b0; #1;
  endtask

  // Raises the sources {peripheral, external, nmi} and measures cycles to the wake pulse.
  task automatic wake(input logic [2:0] src, input int exp_n, input logic [1:0] act);
    int n;
    n = 0;
    @(posedge clk); {irq_p, irq_e, nmi} <= src;
    while (n < 40 && WAKE !== 1'b1) begin @(posedge clk); #1; n++; end
    `CHK(n, exp_n, "wake latency")
    `CHK(WAKE_ACTION, act, "wake action")
    `CHK(CORE_HALT, 1'b0, "core still halted")
    @(posedge clk); {irq_p, irq_e, nmi} <= 3'h0;
  endtask

  task automatic t_reset();
    `CHK({CORE_HALT, PERIPH_CLK_EN, MAIN_OSC_EN, AUX_OSC_EN}, 4'h6, "reset clocks")
    `CHK(GLOBAL_IRQ_ENABLE, 1'b0, "enable after reset")
    `CHK(POWER_MODE, psm_pkg::PM_RUN, "mode after reset")
    `CHK(AUX_SELECTED, 1'b0, "selection after reset")
    $display("test reset done");
  endtask

  task automatic t_gen_write();
    wr(8'hc9, 8'h10); @(posedge clk); #1;
    `CHK(GLOBAL_IRQ_ENABLE, 1'b0, "write to other address")
    wr(8'hc8, 8'hef); @(posedge clk); #1;
    `CHK(GLOBAL_IRQ_ENABLE, 1'b0, "other bits set")
    wr(8'hc8, 8'h10); @(posedge clk); #1;
    `CHK(GLOBAL_IRQ_ENABLE, 1'b1, "enable bit set")
    $display("test gen_write done");
  endtask

  task automatic t_wait_main();
    @(posedge clk); want_aux <= 1'b1; osc_sel <= 1'b1;
    repeat (3) @(posedge clk);
    sleep(1'b0, psm_pkg::CTX_MAIN);
    `CHK(POWER_MODE, psm_pkg::PM_WAIT, "wait entry")
    `CHK(CORE_HALT, 1'b1, "halt in wait")
    `CHK({PERIPH_CLK_EN, MAIN_OSC_EN, AUX_OSC_EN}, 3'h7, "clocks in wait")
    wake(3'b100, 1, psm_pkg::ACT_SERVICE_IRQ);
    `CHK(AUX_SELECTED, 1'b1, "selection after wake")
    $display("test wait_main done");
  endtask

  task automatic t_stop_ext();
    sleep(1'b1, psm_pkg::CTX_NMI);
    `CHK(POWER_MODE, psm_pkg::PM_STOP, "stop entry")
    `CHK({PERIPH_CLK_EN, MAIN_OSC_EN, AUX_OSC_EN, CORE_HALT}, 4'h1, "clocks in stop")
    @(posedge clk); irq_p <= 1'b1;
    repeat (5) @(posedge clk); #1;
    `CHK(POWER_MODE, psm_pkg::PM_STOP, "peripheral irq woke stop")
    wake(3'b110, STAB + 3, psm_pkg::ACT_RESUME);
    `CHK(AUX_SELECTED, 1'b1, "selection after stop")
    $display("test stop_ext done");
  endtask

  task automatic t_wdg();
    @(posedge clk); wdg_act <= 1'b1;
    sleep(1'b1, psm_pkg::CTX_MAIN);
    `CHK(POWER_MODE, psm_pkg::PM_WAIT, "stop under watchdog")
    `CHK(MAIN_OSC_EN, 1'b1, "oscillator under watchdog")
    pulse_reset(1'b1);
    `CHK(RESET_REQ, 1'b1, "watchdog reset in wait")
    `CHK(POWER_MODE, psm_pkg::PM_RUN, "mode after reset")
    @(posedge clk); wdg_act <= 1'b0;
    $display("test wdg done");
  endtask

  task automatic t_stop_reset();
    sleep(1'b1, psm_pkg::CTX_MAIN);
    pulse_reset(1'b1); @(posedge clk); #1;
    `CHK(POWER_MODE, psm_pkg::PM_STOP, "watchdog reset in stop")
    pulse_reset(1'b0);
    `CHK(RESET_REQ, 1'b1, "pin reset in stop")
    `CHK(POWER_MODE, psm_pkg::PM_RUN, "mode after pin reset")
    $display("test stop_reset done");
  endtask

  task automatic t_ctx_irq();
    wr(8'hc8, 8'h10);
    sleep(1'b0, psm_pkg::CTX_IRQ);
    wake(3'b010, 1, psm_pkg::ACT_RESUME);
    sleep(1'b0, psm_pkg::CTX_IRQ);
    wake(3'b001, 1, psm_pkg::ACT_SERVICE_NMI);
    sleep(1'b0, psm_pkg::CTX_MAIN);
    wake(3'b001, 1, psm_pkg::ACT_SERVICE_NMI);
    sleep(1'b0, psm_pkg::CTX_NMI);
    wake(3'b100, 1, psm_pkg::ACT_RESUME);
    $display("test ctx_irq done");
  endtask

  task automatic t_gen_off();
    wr(8'hc8, 8'h00);
    sleep(1'b0, psm_pkg::CTX_NMI);
    @(posedge clk); {irq_p, irq_e, nmi} <= 3'h7;
    repeat (6) @(posedge clk); #1;
    `CHK({CORE_HALT, POWER_MODE}, 3'h5, "woken with enable clear")
    pulse_reset(1'b0);
    `CHK(RESET_REQ, 1'b1, "reset with enable clear")
    @(posedge clk); {irq_p, irq_e, nmi} <= 3'h0;
    $display("test gen_off done");
  endtask

  task automatic t_skip();
    wr(8'hc8, 8'h10);
    @(posedge clk); irq_p <= 1'b1;
    sleep(1'b0, psm_pkg::CTX_MAIN);
    `CHK(SLEEP_SKIP, 1'b1, "skip pulse")
    `CHK({CORE_HALT, POWER_MODE}, 3'h0, "entered with pending irq")
    @(posedge clk); irq_p <= 1'b0;
    $display("test skip done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk); #1;
    t_reset();
    t_gen_write();
    t_wait_main();
    t_stop_ext();
    t_wdg();
    t_stop_reset();
    t_ctx_irq();
    t_gen_off();
    t_skip();
    close_out();
  end
endmodule
